// ==== test/ocw_timer_tb.sv ====
// Testbench for the output compare waveform timer
`timescale 1ns/1ns
module ocw_timer_tb;
	import ocw_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	ocw_cfg_t cfg = '0;
	ocw_mode_t [7:0] ch_mode;
	logic [7:0][15:0] ch_cmp = '0;
	logic [7:0] ch_init_lvl = 8'h00;
	logic load_lvl = 1'b0;
	logic ext_clk = 1'b0;
	logic [7:0] wave_out;
	logic [15:0] count;
	ocw_evt_t evt;
	int error_cnt = 0;
	int checks = 0;

	always #20 mclk = ~mclk;

	ocw_timer ocw_timer_inst (.mclk(mclk), .rst(rst), .cfg(cfg), .ch_mode(ch_mode),
		.ch_cmp(ch_cmp), .ch_init_lvl(ch_init_lvl), .load_lvl(load_lvl),
		.ext_clk(ext_clk), .wave_out(wave_out), .count(count), .evt(evt));

	// ****************************************
	// Helpers
	// ****************************************
	task summarize;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task wait_cnt(input logic [15:0] v);
		int i;
		i = 0;
		while (count !== v && i < 70000) begin
			@(negedge mclk);
			i++;
		end
		if (i == 70000)
			chk("wait", v, count);
	endtask

	// Cycles between two counter steps
	task period(input logic [1:0] src, input logic [7:0] dv, input int exp);
		logic [15:0] c;
		int n;
		@(posedge mclk);
		cfg.src_sel <= src;
		cfg.div <= dv;
		cyc(40);
		c = count;
		n = 0;
		while (count === c && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		c = count;
		n = 0;
		while (count === c && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		chk("period", exp[15:0], n[15:0]);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_load;
		@(posedge mclk);
		load_lvl <= 1'b1;
		ch_init_lvl <= 8'ha5;
		cyc(2);
		chk("load_a5", 16'h00a5, {8'h00, wave_out});
		@(posedge mclk);
		ch_init_lvl <= 8'h00;
		cyc(2);
		chk("load_00", 16'h0000, {8'h00, wave_out});
		@(posedge mclk);
		load_lvl <= 1'b0;
	endtask

	task t_match;
		@(posedge mclk);
		ch_cmp <= {16'h0100, 16'h0100, 16'h0006, 16'h0001, 16'h0100, 16'h0003, 16'h0008, 16'h0005};
		ch_mode[2] <= OCW_MODE_PHASE;
		ch_mode[4] <= OCW_MODE_SETRST;
		cfg.clr_en <= 1'b1;
		cfg.clr_sel <= 3'h1;
		cfg.run <= 1'b1;
		wait_cnt(16'h0005);
		cyc(1);
		chk("count", 16'h0006, count);
		chk("match", 16'h0001, {8'h00, evt.match});
		chk("cmp0", 16'h0001, {15'h0, evt.cmp0});
		chk("wave", 16'h0015, {8'h00, wave_out});
		cyc(1);
		// Channel 0 pulse has ended; channel 5 matches at the next count
		chk("match_end", 16'h0020, {8'h00, evt.match});
		wait_cnt(16'h0008);
		cyc(1);
		chk("clear", 16'h0000, count);
		chk("no_ovf", 16'h0000, {15'h0, evt.ovf});
		chk("cmp1", 16'h0001, {15'h0, evt.cmp1});
		chk("wave", 16'h0026, {8'h00, wave_out});
		wait_cnt(16'h0003);
		cyc(1);
		chk("toggle", 16'h0000, {15'h0, wave_out[2]});
	endtask

	task t_ext;
		for (int e = 0; e < 3; e++) begin
			logic [15:0] c;
			@(posedge mclk);
			cfg.src_sel <= OCW_SRC_EXT;
			cfg.div <= 8'h00;
			cfg.clr_en <= 1'b0;
			cfg.edge_sel <= e[1:0];
			cyc(8);
			c = count;
			repeat (20) begin
				repeat (4) @(posedge mclk);
				ext_clk <= ~ext_clk;
			end
			cyc(8);
			chk("ext", c + ((e == 2) ? 16'd20 : 16'd10), count);
		end
	endtask

	// Compare just ahead of the counter so the clear comes without a wrap
	task t_fixed;
		logic [15:0] c;
		c = count + 16'h0010;
		@(posedge mclk);
		cfg.src_sel <= OCW_SRC_MCLK;
		cfg.fixed_clear <= 1'b1;
		ch_cmp[0] <= c;
		wait_cnt(c);
		cyc(1);
		chk("fixed", 16'h0000, count);
		@(posedge mclk);
		cfg.fixed_clear <= 1'b0;
	endtask

	task t_ovf_stop;
		logic [15:0] c;
		wait_cnt(16'hffff);
		cyc(1);
		chk("wrap", 16'h0000, count);
		chk("ovf", 16'h0001, {15'h0, evt.ovf});
		@(posedge mclk);
		cfg.run <= 1'b0;
		cyc(2);
		c = count;
		cyc(10);
		chk("stop", c, count);
	endtask

	initial begin
		for (int i = 0; i < 8; i++)
			ch_mode[i] = OCW_MODE_SINGLE;
		cyc(1);
		chk("rst_count", 16'h0000, count);
		chk("rst_wave", 16'h0000, {8'h00, wave_out});
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_load();
		t_match();
		period(OCW_SRC_MCLK, 8'h02, 3);
		period(OCW_SRC_DIV4, 8'h00, 4);
		period(OCW_SRC_DIV8, 8'h01, 16);
		t_ext();
		t_fixed();
		t_ovf_stop();
		summarize();
	end

	// Whole run is about 66000 cycles, mostly the wrap
	initial begin
		repeat (90000) @(posedge mclk);
		error_cnt++;
		summarize();
	end
endmodule // ocw_timer_tb

// ==== verilog/ocw_chan.sv ====
// Module: one waveform output channel with its compare logic
`timescale 1ns/1ns
module ocw_chan (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Counter side
	input wire logic tick,
	input wire logic [15:0] cnt,
	input wire logic [15:0] cmp_val,
	input wire logic [15:0] partner_val,
	input wire ocw_pkg::ocw_mode_t mode,
	input wire logic init_lvl,
	input wire logic load_lvl,
	// Results
	output logic hit,
	output logic level
);
	import ocw_pkg::*;

	logic level_r;
	logic level_nxt;
	logic partner_hit;

	assign hit = tick && (cnt == cmp_val);
	assign partner_hit = tick && (cnt == partner_val);

	always_comb begin
		level_nxt = level_r;
		if (load_lvl) begin
			level_nxt = init_lvl;
		end else begin
			unique case (mode)
				OCW_MODE_SINGLE: begin
					// Level set at own match, cleared at the pair match
					if (hit) begin
						level_nxt = 1'b1;
					end else if (partner_hit) begin
						level_nxt = 1'b0;
					end
				end
				OCW_MODE_PHASE: begin
					if (hit) begin
						level_nxt = ~level_r;
					end
				end
				OCW_MODE_SETRST: begin
					// Set wins when both compare values coincide
					if (hit) begin
						level_nxt = 1'b1;
					end else if (partner_hit) begin
						level_nxt = 1'b0;
					end
				end
				default: begin
					level_nxt = level_r;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			level_r <= 1'b0;
		end else begin
			level_r <= level_nxt;
		end
	end

	assign level = level_r;

endmodule // ocw_chan

// ==== verilog/ocw_pkg.sv ====
// Package: constants and carrier types for the output compare waveform timer
package ocw_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int OCW_CH_NUM = 8;
	localparam int OCW_CNT_W = 16;
	localparam int OCW_DIV_W = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] OCW_CNT_RST = 16'h0000;
	localparam logic [7:0] OCW_DIV_RST = 8'h00;
	localparam logic [7:0] OCW_LVL_RST = 8'h00;

	// ****************************************
	// Count source selection
	// ****************************************
	localparam logic [1:0] OCW_SRC_MCLK = 2'h0;
	localparam logic [1:0] OCW_SRC_DIV4 = 2'h1;
	localparam logic [1:0] OCW_SRC_DIV8 = 2'h2;
	localparam logic [1:0] OCW_SRC_EXT = 2'h3;
	localparam int OCW_PRE4 = 4;
	localparam int OCW_PRE8 = 8;

	// ****************************************
	// Edge selection
	// ****************************************
	localparam logic [1:0] OCW_EDGE_RISE = 2'h0;
	localparam logic [1:0] OCW_EDGE_FALL = 2'h1;
	localparam logic [1:0] OCW_EDGE_BOTH = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		OCW_MODE_SINGLE = 3'h1,
		OCW_MODE_PHASE = 3'h2,
		OCW_MODE_SETRST = 3'h4
	} ocw_mode_t;

	typedef struct packed {
		logic run;
		logic fixed_clear;
		logic clr_en;
		logic [2:0] clr_sel;
		logic [1:0] src_sel;
		logic [1:0] edge_sel;
		logic [7:0] div;
	} ocw_cfg_t;

	typedef struct packed {
		logic ovf;
		logic [7:0] match;
		logic cmp0;
		logic cmp1;
	} ocw_evt_t;

endpackage

// ==== verilog/ocw_timer.sv ====
// Module: output compare waveform timer top
//
// Contract
// - Eight channels, each with own compare register.
// - Per channel single, phase-delayed or set/reset mode.
// - Compare equals counter updates that channel output.
// - Flag overflow and compare match events 0, 1.
// - Match changes level on the channel's pin.
// - Selectable match clears counter; else keeps counting.
// - Fixed-clear variant always clears on channel 0 compare match.
// - Count source divided by divider setting plus one.
// - Separate match event per register plus overflow.
// - Start/stop setting selects counting or stopped.
// - Counter advances on configurable count source edge; the mclk source counts every mclk cycle and ignores edge select.
`timescale 1ns/1ns
module ocw_timer #(
	parameter int CH_NUM = ocw_pkg::OCW_CH_NUM,
	parameter int CNT_W = ocw_pkg::OCW_CNT_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration
	input wire ocw_pkg::ocw_cfg_t cfg,
	input wire ocw_pkg::ocw_mode_t [7:0] ch_mode,
	input wire logic [7:0][15:0] ch_cmp,
	input wire logic [7:0] ch_init_lvl,
	input wire logic load_lvl,
	// External count source pin
	input wire logic ext_clk,
	// Waveform outputs
	output logic [7:0] wave_out,
	// Status
	output logic [15:0] count,
	output ocw_pkg::ocw_evt_t evt
);
	import ocw_pkg::*;

	// ****************************************
	// Count source and edge select
	// ****************************************
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_d_r;
	logic [2:0] pre_r;
	logic [2:0] pre_nxt;
	logic src_lvl_r;
	logic src_lvl_nxt;
	logic src_prev_r;
	logic src_edge;
	logic src_lvl;

	// Prescaled sources are square levels so edge select applies uniformly
	always_comb begin
		pre_nxt = pre_r + 3'h1;
		unique case (cfg.src_sel)
			OCW_SRC_MCLK: src_lvl = 1'b0;
			OCW_SRC_DIV4: src_lvl = pre_r[1];
			OCW_SRC_DIV8: src_lvl = pre_r[2];
			OCW_SRC_EXT: src_lvl = ext_d_r;
			default: src_lvl = 1'b0;
		endcase
		src_lvl_nxt = src_lvl;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_d_r <= 1'b0;
			pre_r <= 3'h0;
			src_lvl_r <= 1'b0;
			src_prev_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_clk;
			ext_s2_r <= ext_s1_r;
			ext_d_r <= ext_s2_r;
			pre_r <= pre_nxt;
			src_lvl_r <= src_lvl_nxt;
			src_prev_r <= src_lvl_r;
		end
	end

	always_comb begin
		if (cfg.src_sel == OCW_SRC_MCLK) begin
			src_edge = 1'b1;
		end else begin
			unique case (cfg.edge_sel)
				OCW_EDGE_RISE: src_edge = src_lvl_r && !src_prev_r;
				OCW_EDGE_FALL: src_edge = !src_lvl_r && src_prev_r;
				OCW_EDGE_BOTH: src_edge = src_lvl_r ^ src_prev_r;
				default: src_edge = src_lvl_r && !src_prev_r;
			endcase
		end
	end

	// ****************************************
	// Divider (n + 1)
	// ****************************************
	logic [7:0] div_r;
	logic [7:0] div_nxt;
	logic tick;

	always_comb begin
		div_nxt = div_r;
		tick = 1'b0;
		// Stopping restarts the divider so a restart counts a full period
		if (!cfg.run) begin
			div_nxt = OCW_DIV_RST;
		end else if (src_edge) begin
			if (div_r >= cfg.div) begin
				div_nxt = OCW_DIV_RST;
				tick = 1'b1;
			end else begin
				div_nxt = div_r + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_r <= OCW_DIV_RST;
		end else begin
			div_r <= div_nxt;
		end
	end

	// ****************************************
	// Channels
	// ****************************************
	logic [7:0] hit;
	logic clr_hit;

	for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
		ocw_chan u_chan (
			.mclk(mclk),
			.rst(rst),
			.tick(tick),
			.cnt(count),
			.cmp_val(ch_cmp[i]),
			.partner_val(ch_cmp[i ^ 1]),
			.mode(ch_mode[i]),
			.init_lvl(ch_init_lvl[i]),
			.load_lvl(load_lvl),
			.hit(hit[i]),
			.level(wave_out[i])
		);
	end

	// Fixed-clear variant always uses channel 0 compare
	assign clr_hit = cfg.fixed_clear ? hit[0] : (cfg.clr_en && hit[cfg.clr_sel]);

	// ****************************************
	// Counter
	// ****************************************
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic ovf;

	always_comb begin
		cnt_nxt = cnt_r;
		ovf = 1'b0;
		if (tick) begin
			if (clr_hit) begin
				cnt_nxt = OCW_CNT_RST;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
				ovf = (cnt_r == 16'hffff);
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r <= OCW_CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign count = cnt_r;

	// ****************************************
	// Event pulses
	// ****************************************
	ocw_evt_t evt_r;
	ocw_evt_t evt_nxt;

	always_comb begin
		evt_nxt.ovf = ovf;
		evt_nxt.match = hit;
		evt_nxt.cmp0 = hit[0];
		evt_nxt.cmp1 = hit[1];
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			evt_r <= '0;
		end else begin
			evt_r <= evt_nxt;
		end
	end

	assign evt = evt_r;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_wrap;
		tick && !clr_hit && cnt_r == 16'hffff;
	endsequence

	a_ovf_wrap: assert property (@(posedge mclk) disable iff (rst)
		s_wrap |=> evt.ovf && count == 16'h0000)
		else $error("overflow not flagged on wrap");
	a_cnt_inc: assert property (@(posedge mclk) disable iff (rst)
		tick && !clr_hit |=> count == $past(count) + 16'h0001)
		else $error("counter did not advance");
	a_stop_hold: assert property (@(posedge mclk) disable iff (rst)
		!cfg.run |=> $stable(count))
		else $error("counter moved while stopped");
	a_fixed_clr: assert property (@(posedge mclk) disable iff (rst)
		cfg.fixed_clear && tick && count == ch_cmp[0] |=> count == 16'h0000)
		else $error("fixed clear missed");
	a_sel_clr: assert property (@(posedge mclk) disable iff (rst)
		!cfg.fixed_clear && cfg.clr_en && tick && count == ch_cmp[cfg.clr_sel]
		|=> count == 16'h0000)
		else $error("selected clear missed");
	a_div_one: assert property (@(posedge mclk) disable iff (rst)
		cfg.run && cfg.div == 8'h00 && src_edge |-> tick)
		else $error("undivided source lost a tick");
	a_div_gap: assert property (@(posedge mclk) disable iff (rst)
		tick && cfg.div != 8'h00 |=> !tick)
		else $error("divided ticks too close");
	a_match_evt: assert property (@(posedge mclk) disable iff (rst)
		tick && count == ch_cmp[0] |=> evt.cmp0 && evt.match[0])
		else $error("match event missing");
	a_phase_tog: assert property (@(posedge mclk) disable iff (rst)
		ch_mode[2] == OCW_MODE_PHASE && !load_lvl && tick && count == ch_cmp[2]
		|=> wave_out[2] != $past(wave_out[2]))
		else $error("phase output did not toggle");
	// Pin edge shows up two stages after the second sync flop
	a_rise_edge: assert property (@(posedge mclk) disable iff (rst)
		cfg.src_sel == OCW_SRC_EXT && $past(cfg.src_sel) == OCW_SRC_EXT
		&& $past(cfg.src_sel, 2) == OCW_SRC_EXT && cfg.edge_sel == OCW_EDGE_RISE && src_edge
		|-> $past(ext_s2_r, 2) && !$past(ext_s2_r, 3))
		else $error("edge select wrong");
	a_fall_edge: assert property (@(posedge mclk) disable iff (rst)
		cfg.src_sel == OCW_SRC_EXT && $past(cfg.src_sel) == OCW_SRC_EXT
		&& $past(cfg.src_sel, 2) == OCW_SRC_EXT && cfg.edge_sel == OCW_EDGE_FALL && src_edge
		|-> !$past(ext_s2_r, 2) && $past(ext_s2_r, 3))
		else $error("falling edge select wrong");
	a_clr_no_ovf: assert property (@(posedge mclk) disable iff (rst)
		tick && clr_hit |=> !evt.ovf && count == 16'h0000)
		else $error("clearing tick raised overflow");
	a_keep_count: assert property (@(posedge mclk) disable iff (rst)
		!cfg.fixed_clear && !cfg.clr_en && tick
		|=> count == $past(count) + 16'h0001)
		else $error("counter stalled with clearing off");
	a_stop_quiet: assert property (@(posedge mclk) disable iff (rst)
		!cfg.run && !load_lvl |=> evt == '0 && $stable(wave_out))
		else $error("stopped timer produced activity");
	a_load_lvl: assert property (@(posedge mclk) disable iff (rst)
		load_lvl |=> wave_out == $past(ch_init_lvl))
		else $error("initial level not loaded");
	a_evt_cmp1: assert property (@(posedge mclk) disable iff (rst)
		tick && count == ch_cmp[1] |=> evt.cmp1 && evt.match[1])
		else $error("second match event missing");
	a_evt_idle: assert property (@(posedge mclk) disable iff (rst)
		!tick |=> evt.match == 8'h00 && !evt.ovf)
		else $error("event without a tick");
	a_src_mclk: assert property (@(posedge mclk) disable iff (rst)
		cfg.run && cfg.src_sel == OCW_SRC_MCLK && cfg.div == 8'h00 |-> tick)
		else $error("undivided clock source missed a tick");

	// ****************************************
	// Per-channel level checks
	// ****************************************
	for (genvar j = 0; j < CH_NUM; j++) begin : g_chk
		// Single and set/reset share own-set, pair-clear; set wins a tie
		sequence s_lvl_set;
			(ch_mode[j] == OCW_MODE_SINGLE || ch_mode[j] == OCW_MODE_SETRST)
				&& !load_lvl && tick && count == ch_cmp[j];
		endsequence
		sequence s_lvl_clr;
			(ch_mode[j] == OCW_MODE_SINGLE || ch_mode[j] == OCW_MODE_SETRST)
				&& !load_lvl && tick && count == ch_cmp[j ^ 1] && count != ch_cmp[j];
		endsequence
		sequence s_lvl_tog;
			ch_mode[j] == OCW_MODE_PHASE && !load_lvl && tick && count == ch_cmp[j];
		endsequence

		a_lvl_set: assert property (@(posedge mclk) disable iff (rst)
			s_lvl_set |=> wave_out[j])
			else $error("own match did not set level");
		a_lvl_clr: assert property (@(posedge mclk) disable iff (rst)
			s_lvl_clr |=> !wave_out[j])
			else $error("pair match did not clear level");
		a_lvl_tog: assert property (@(posedge mclk) disable iff (rst)
			s_lvl_tog |=> wave_out[j] != $past(wave_out[j]))
			else $error("phase level did not toggle");
	end

endmodule // ocw_timer
